//--- inc/flash_cmd_pkg.sv
// Constants and types shared by the serial flash command decoder
// ==========================================================
// Notes on behaviour
// R1: 06 sets write enable, both modes
// R2: 04 clears write enable, both modes
// R3: 9F identification, single-lane only
// R4: 05 returns status byte, both modes
// R5: 01 writes status; quad uses four lanes
// R6: 03 read, single-lane, no dummy cycles
// R7: 0B fast read, both modes
// R8: BB dual read, single-lane only
// R9: EB quad read, both modes
// R10: Host drives lanes two cycles after indicator
// R11: Toggling indicator enters continuous read mode
// R12: Non-toggling indicator leaves continuous read mode
// R13: Host sends all-ones or all-zeros otherwise
// R14: 02 program both; 38 single-lane only
// R15: 20, 52, D8 erase with address
// R16: 60 and C7 whole-array erase
// R17: B9 sleeps, AB wakes, signature single-lane
// R18: 90 order set by address 00 or 01
// R19: 2B reads, 2F writes security register
// R20: E7 word quad read, single-lane only
// R21: Array reads FF, status 00 delivered
// R22: Writes rejected during power-up delay
// R23: Dummy count four or six agreed
// R24: Unknown opcodes ignored until deselect
package flash_cmd_pkg;
  localparam logic [7:0] write_enable_cmd = 8'h06;
  localparam logic [7:0] write_disable_cmd = 8'h04;
  localparam logic [7:0] read_identification_cmd = 8'h9f;
  localparam logic [7:0] status_read_cmd = 8'h05;
  localparam logic [7:0] status_write_cmd = 8'h01;
  localparam logic [7:0] normal_read_cmd = 8'h03;
  localparam logic [7:0] fast_read_cmd = 8'h0b;
  localparam logic [7:0] dual_lane_read_cmd = 8'hbb;
  localparam logic [7:0] quad_lane_read_cmd = 8'heb;
  localparam logic [7:0] word_quad_read_cmd = 8'he7;
  localparam logic [7:0] page_program_cmd = 8'h02;
  localparam logic [7:0] quad_page_program_cmd = 8'h38;
  localparam logic [7:0] sector_erase_cmd = 8'h20;
  localparam logic [7:0] half_block_erase_cmd = 8'h52;
  localparam logic [7:0] block_erase_cmd = 8'hd8;
  localparam logic [7:0] chip_erase_cmd = 8'h60;
  localparam logic [7:0] chip_erase_alt_cmd = 8'hc7;
  localparam logic [7:0] deep_sleep_cmd = 8'hb9;
  localparam logic [7:0] deep_sleep_release_cmd = 8'hab;
  localparam logic [7:0] maker_device_code_read_cmd = 8'h90;
  localparam logic [7:0] security_reg_read_cmd = 8'h2b;
  localparam logic [7:0] security_reg_write_cmd = 8'h2f;
  // Arbitrary identity values, not taken from any part
  localparam logic [7:0] maker_code = 8'h5c;
  localparam logic [7:0] device_code = 8'h3a;
  localparam logic [7:0] memory_type_code = 8'h71;
  localparam logic [7:0] signature_code = 8'h36;
  localparam logic [7:0] erased_byte = 8'hff;
  localparam logic [7:0] status_reset = 8'h00;
  localparam logic [7:0] security_reset = 8'h00;
  localparam logic [7:0] addr_maker_first = 8'h00;
  localparam int wel_bit = 1;
  localparam int addr_bytes = 3;
  localparam int dummy_fast = 8;
  localparam int dummy_dual = 4;
  localparam int dummy_quad_slow = 4;
  localparam int dummy_quad_fast = 6;
  localparam int indicator_cycles_quad = 2;
  localparam int indicator_cycles_dual = 4;
  // Power-up write delay in microseconds; the least figure is kept
  localparam int power_up_write_delay_us = 1000;
  localparam int clk_mhz = 125;
  localparam int power_up_write_delay_cycles =
    power_up_write_delay_us * clk_mhz;
  typedef enum logic [5:0] {
    st_idle = 6'h01,
    st_opcode = 6'h02,
    st_addr = 6'h04,
    st_dummy = 6'h08,
    st_data = 6'h10,
    st_ignore = 6'h20
  } phase_type;
endpackage : flash_cmd_pkg

//--- inc/lane_shift_if.sv
// Interface between the frame engine and the lane shifter
`timescale 1ns/1ps
interface lane_shift_if;
  logic load;
  logic [7:0] load_byte;
  logic [2:0] width;
  logic shift;
  logic [3:0] lanes_out;
  logic byte_done;
  modport engine (output load, output load_byte, output width,
    output shift, input lanes_out, input byte_done);
  modport shifter (input load, input load_byte, input width,
    input shift, output lanes_out, output byte_done);
endinterface : lane_shift_if

//--- hdl/lane_shifter.sv
// Output byte shifter for one, two or four lanes
`timescale 1ns/1ps
module lane_shifter (
  input wire logic clk,
  input wire logic rst_n,
  lane_shift_if.shifter port
);
  import flash_cmd_pkg::*;
  logic [7:0] shreg;
  logic [3:0] left;
  // ==========================================================
  // Shift register, most significant bits leave first
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      shreg <= 8'h00;
      left <= 4'h0;
    end else if (port.load) begin
      shreg <= port.load_byte;
      left <= 4'h8;
    end else if (port.shift && left != 4'h0) begin
      shreg <= shreg << port.width;
      left <= left - {1'b0, port.width};
    end
  end
  always_comb begin
    case (port.width)
      3'd4: port.lanes_out = shreg[7:4];
      3'd2: port.lanes_out = {2'b00, shreg[7:6]};
      default: port.lanes_out = {2'b00, shreg[7], 1'b0};
    endcase
  end
  // Last group of the byte is now being shifted out
  assign port.byte_done = port.shift && (left == {1'b0, port.width});
endmodule : lane_shifter

//--- hdl/flash_cmd_decoder.sv
// Command decoder and sequencer of a serial NOR flash
`timescale 1ns/1ps
module flash_cmd_decoder #(
  parameter int power_up_cycles =
    flash_cmd_pkg::power_up_write_delay_cycles
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic cs_n_pin,
  input wire logic sclk_pin,
  input wire logic [3:0] io_in,
  output logic [3:0] io_out,
  output logic [3:0] io_oe,
  input wire logic quad_command_mode,
  input wire logic six_dummy,
  output logic write_enabled,
  output logic deep_sleep,
  output logic continuous_mode,
  output logic [7:0] status,
  output logic [7:0] security,
  output logic erase_start,
  output logic program_start,
  output logic [2:0] erase_kind,
  output logic [23:0] op_addr,
  output logic [7:0] prog_data,
  output logic prog_valid
);
  import flash_cmd_pkg::*;

  // ==========================================================
  // Pin synchronisers
  logic [1:0] cs_sync, clk_sync;
  logic [3:0] io_s1, io_s2;
  logic sclk_prev;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cs_sync <= 2'b11;
      clk_sync <= 2'b00;
      io_s1 <= 4'h0;
      io_s2 <= 4'h0;
      sclk_prev <= 1'b0;
    end else begin
      cs_sync <= {cs_sync[0], cs_n_pin};
      clk_sync <= {clk_sync[0], sclk_pin};
      io_s1 <= io_in;
      io_s2 <= io_s1;
      sclk_prev <= clk_sync[1];
    end
  end
  logic cs_n, rise, fall;
  assign cs_n = cs_sync[1];
  assign rise = !cs_n && clk_sync[1] && !sclk_prev;
  assign fall = !cs_n && !clk_sync[1] && sclk_prev;

  // ==========================================================
  // Power-up write inhibit
  logic [31:0] pu_count;
  logic pu_done;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pu_count <= 32'h0;
      pu_done <= 1'b0;
    end else if (!pu_done) begin
      pu_count <= pu_count + 32'h1;
      // Writes stay refused until the delay has run out [R22]
      if (pu_count >= 32'(power_up_cycles) - 32'h1) pu_done <= 1'b1;
    end
  end

  // ==========================================================
  // Frame state
  phase_type phase;
  logic [7:0] opcode, in_byte;
  logic [2:0] in_cnt;
  logic [1:0] byte_idx;
  logic [3:0] dummy_cnt;
  logic [2:0] in_width, out_width;
  logic [23:0] addr;
  logic [7:0] indicator;
  logic skip_opcode, data_out;
  logic [1:0] data_bytes;
  logic [3:0] lanes_now;
  logic [7:0] shifted_in;
  logic byte_in;

  // Collect one lane group per rising edge
  always_comb begin
    case (in_width)
      3'd4: shifted_in = {in_byte[3:0], io_s2};
      3'd2: shifted_in = {in_byte[5:0], io_s2[1:0]};
      default: shifted_in = {in_byte[6:0], io_s2[0]};
    endcase
  end
  assign byte_in = rise && (in_cnt + in_width == 3'd0 ||
    {1'b0, in_cnt} + {1'b0, in_width} == 4'd8);

  // Decide whether opcode is legal in the current mode
  function automatic logic legal(input logic [7:0] op, input logic q);
    case (op)
      write_enable_cmd, write_disable_cmd, status_read_cmd,
      status_write_cmd, fast_read_cmd, quad_lane_read_cmd, // [R7] [R9]
      page_program_cmd, sector_erase_cmd, half_block_erase_cmd,
      block_erase_cmd, chip_erase_cmd, chip_erase_alt_cmd,
      deep_sleep_cmd, deep_sleep_release_cmd, security_reg_read_cmd,
      security_reg_write_cmd: legal = 1'b1;
      read_identification_cmd, normal_read_cmd, dual_lane_read_cmd,
      quad_page_program_cmd, maker_device_code_read_cmd,
      word_quad_read_cmd: legal = !q; // [R3] [R6] [R8] [R14] [R18] [R20]
      default: legal = 1'b0;
    endcase
  endfunction

  function automatic logic is_write(input logic [7:0] op);
    is_write = op inside {status_write_cmd, page_program_cmd,
      quad_page_program_cmd, sector_erase_cmd, half_block_erase_cmd,
      block_erase_cmd, chip_erase_cmd, chip_erase_alt_cmd,
      security_reg_write_cmd};
  endfunction

  function automatic logic has_addr(input logic [7:0] op);
    has_addr = op inside {normal_read_cmd, fast_read_cmd,
      dual_lane_read_cmd, quad_lane_read_cmd, word_quad_read_cmd,
      page_program_cmd, quad_page_program_cmd, sector_erase_cmd,
      half_block_erase_cmd, block_erase_cmd, maker_device_code_read_cmd};
  endfunction

  // Lane width used for address and data after the opcode
  function automatic logic [2:0] lane_width(input logic [7:0] op,
      input logic q);
    if (q) lane_width = 3'd4;
    else if (op == dual_lane_read_cmd) lane_width = 3'd2;
    else if (op inside {quad_lane_read_cmd, word_quad_read_cmd,
      quad_page_program_cmd}) lane_width = 3'd4;
    else lane_width = 3'd1;
  endfunction

  // Dummy clocks: indicator cycles folded in for EB/BB/E7 [R23]
  function automatic logic [3:0] dummy_of(input logic [7:0] op,
      input logic q, input logic six);
    case (op)
      fast_read_cmd: dummy_of = q ? 4'(dummy_quad_slow) : 4'(dummy_fast);
      dual_lane_read_cmd: dummy_of = 4'(dummy_dual);
      quad_lane_read_cmd: dummy_of = six ? 4'(dummy_quad_fast)
                                         : 4'(dummy_quad_slow);
      word_quad_read_cmd: dummy_of = 4'(dummy_quad_slow);
      read_identification_cmd: dummy_of = 4'h0;
      default: dummy_of = 4'h0;
    endcase
  endfunction

  lane_shift_if sh ();
  lane_shifter u_shift (.clk(clk), .rst_n(rst_n), .port(sh));

  // ==========================================================
  // Frame sequencer, one concern per block
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      phase <= st_idle;
      opcode <= 8'h00;
      in_byte <= 8'h00;
      in_cnt <= 3'd0;
      byte_idx <= 2'd0;
      dummy_cnt <= 4'h0;
      in_width <= 3'd1;
      addr <= 24'h0;
      indicator <= 8'h00;
      data_out <= 1'b0;
    end else if (cs_n) begin
      phase <= st_idle;
      in_cnt <= 3'd0;
      byte_idx <= 2'd0;
      data_out <= 1'b0;
      in_width <= 3'd1;
    end else begin
      if (phase == st_idle) begin
        // Continuous mode skips the opcode phase [R11]
        if (continuous_mode) begin
          phase <= st_addr;
          opcode <= quad_lane_read_cmd;
          in_width <= 3'd4;
          // Dummy count reloads so the indicator is read again [R12]
          dummy_cnt <= dummy_of(quad_lane_read_cmd, quad_command_mode,
            six_dummy);
        end else begin
          phase <= st_opcode;
          in_width <= quad_command_mode ? 3'd4 : 3'd1; // [R5]
        end
      end else if (rise) begin
        in_byte <= shifted_in;
        in_cnt <= in_cnt + in_width;
        case (phase)
          st_opcode: if (byte_in) begin
            opcode <= shifted_in;
            in_cnt <= 3'd0;
            in_width <= lane_width(shifted_in, quad_command_mode);
            dummy_cnt <= dummy_of(shifted_in, quad_command_mode,
              six_dummy);
            if (!legal(shifted_in, quad_command_mode))
              phase <= st_ignore; // [R24]
            else if (has_addr(shifted_in)) phase <= st_addr;
            else phase <= st_data;
          end
          st_addr: if (byte_in) begin
            addr <= {addr[15:0], shifted_in};
            in_cnt <= 3'd0;
            byte_idx <= byte_idx + 2'd1;
            if (byte_idx == 2'(addr_bytes - 1)) begin
              byte_idx <= 2'd0;
              // Mode indicator follows the address for EB [R11]
              phase <= (dummy_cnt == 4'h0) ? st_data : st_dummy;
            end
          end
          st_dummy: begin
            if (opcode == quad_lane_read_cmd &&
                dummy_of(opcode, quad_command_mode, six_dummy)
                - dummy_cnt < 4'(indicator_cycles_quad))
              indicator <= {indicator[3:0], io_s2};
            dummy_cnt <= dummy_cnt - 4'h1;
            if (dummy_cnt == 4'h1) begin
              phase <= st_data;
              in_cnt <= 3'd0;
              data_out <= 1'b1;
            end
          end
          st_data: if (byte_in) in_cnt <= 3'd0;
          default: ;
        endcase
      end
      if (phase == st_data && !data_out && opcode inside
          {read_identification_cmd, status_read_cmd, normal_read_cmd,
           security_reg_read_cmd, deep_sleep_release_cmd,
           maker_device_code_read_cmd})
        data_out <= 1'b1;
    end
  end

  // ==========================================================
  // Indicator test: all four bit pairs of the two nibbles must differ
  logic toggling;
  assign toggling = &(indicator[7:4] ^ indicator[3:0]);
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) continuous_mode <= 1'b0;
    else if (phase == st_dummy && rise && opcode == quad_lane_read_cmd
             && dummy_cnt == 4'h1)
      continuous_mode <= toggling; // [R11] [R12]
  end

  // ==========================================================
  // Output byte choice and shifter feed
  logic [7:0] out_byte;
  always_comb begin
    case (opcode)
      status_read_cmd: out_byte = status; // [R4]
      security_reg_read_cmd: out_byte = security; // [R19]
      read_identification_cmd: out_byte = data_bytes == 2'd0 ? maker_code
        : data_bytes == 2'd1 ? memory_type_code : device_code; // [R3]
      deep_sleep_release_cmd: out_byte = signature_code; // [R17]
      maker_device_code_read_cmd: out_byte =
        ((addr[7:0] == addr_maker_first) ^ data_bytes[0]) ? maker_code
        : device_code; // [R18]
      default: out_byte = erased_byte; // [R21]
    endcase
  end
  logic out_started;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      out_started <= 1'b0;
      data_bytes <= 2'd0;
    end else if (cs_n) begin
      out_started <= 1'b0;
      data_bytes <= 2'd0;
    end else if (data_out && !out_started) out_started <= 1'b1;
    else if (sh.byte_done) data_bytes <= data_bytes + 2'd1;
  end
  assign out_width = (opcode == deep_sleep_release_cmd &&
    quad_command_mode) ? 3'd1 : in_width;
  assign sh.width = out_width;
  assign sh.load = (data_out && !out_started) || sh.byte_done;
  assign sh.load_byte = out_byte;
  // First fall after the load keeps the leading group on the lanes,
  // otherwise the host would never see the top bit of the first byte
  logic shift_armed;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) shift_armed <= 1'b0;
    else if (cs_n || !out_started) shift_armed <= 1'b0;
    else if (fall) shift_armed <= 1'b1;
  end
  assign sh.shift = fall && shift_armed; // [R4]
  // Lanes driven only while a read returns data
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      io_out <= 4'h0;
      io_oe <= 4'h0;
    end else if (cs_n || !out_started) begin
      io_out <= 4'h0;
      io_oe <= 4'h0;
    end else begin
      io_out <= out_width == 3'd1 ? {2'b00, sh.lanes_out[1], 1'b0}
                                  : sh.lanes_out;
      io_oe <= out_width == 3'd4 ? 4'hf
             : out_width == 3'd2 ? 4'h3 : 4'h2;
    end
  end

  // ==========================================================
  // Commands that take effect on deselect
  logic cs_rise;
  logic cs_prev;
  logic complete;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) cs_prev <= 1'b1;
    else cs_prev <= cs_n;
  end
  assign cs_rise = cs_n && !cs_prev;
  assign complete = (phase == st_data) && in_cnt == 3'd0;
  logic write_ok;
  assign write_ok = pu_done && write_enabled && !deep_sleep &&
    is_write(opcode) && complete && cs_rise; // [R22]

  // Data bytes taken by program and register writes
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      prog_data <= 8'h00;
      prog_valid <= 1'b0;
    end else begin
      prog_valid <= phase == st_data && byte_in &&
        opcode inside {page_program_cmd, quad_page_program_cmd}; // [R14]
      if (phase == st_data && byte_in) prog_data <= shifted_in;
    end
  end

  // Write enable latch, status and security registers
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      write_enabled <= 1'b0;
      status <= status_reset; // [R21]
      security <= security_reset;
    end else if (cs_rise && !deep_sleep && phase != st_ignore) begin
      if (opcode == write_enable_cmd && phase == st_data)
        write_enabled <= 1'b1; // [R1]
      else if (opcode == write_disable_cmd && phase == st_data)
        write_enabled <= 1'b0; // [R2]
      else if (write_ok) begin
        write_enabled <= 1'b0;
        if (opcode == status_write_cmd) status <= prog_data; // [R5]
        if (opcode == security_reg_write_cmd)
          security <= prog_data; // [R19]
      end
      status[wel_bit] <= 1'b0;
    end else status[wel_bit] <= write_enabled;
  end

  // Erase and program launch pulses
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      erase_start <= 1'b0;
      program_start <= 1'b0;
      erase_kind <= 3'd0;
      op_addr <= 24'h0;
    end else begin
      erase_start <= write_ok && opcode inside {sector_erase_cmd,
        half_block_erase_cmd, block_erase_cmd, chip_erase_cmd,
        chip_erase_alt_cmd}; // [R15] [R16]
      program_start <= write_ok && opcode inside {page_program_cmd,
        quad_page_program_cmd}; // [R14]
      if (write_ok) begin
        op_addr <= addr;
        erase_kind <= opcode == sector_erase_cmd ? 3'd1
          : opcode == half_block_erase_cmd ? 3'd2
          : opcode == block_erase_cmd ? 3'd3 : 3'd4;
      end
    end
  end

  // Deep power-down entry and release
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) deep_sleep <= 1'b0;
    else if (cs_rise && phase == st_data) begin
      if (opcode == deep_sleep_cmd) deep_sleep <= 1'b1; // [R17]
      else if (opcode == deep_sleep_release_cmd)
        deep_sleep <= 1'b0; // [R17]
    end
  end

  // ==========================================================
  // Checks
  wel_set_a: assert property (@(posedge clk) disable iff (!rst_n)
    cs_rise && phase == st_data && opcode == write_enable_cmd &&
    !deep_sleep |=> write_enabled) else $error("wel not set"); // [R1]
  wel_clear_a: assert property (@(posedge clk) disable iff (!rst_n)
    cs_rise && phase == st_data && opcode == write_disable_cmd &&
    !deep_sleep |=> !write_enabled) else $error("wel kept"); // [R2]
  early_write_a: assert property (@(posedge clk) disable iff (!rst_n)
    !pu_done |=> !erase_start && !program_start)
    else $error("write before delay"); // [R22]
  quad_illegal_a: assert property (@(posedge clk) disable iff (!rst_n)
    phase == st_opcode && byte_in && quad_command_mode &&
    shifted_in == read_identification_cmd |=> phase == st_ignore)
    else $error("9f taken in quad"); // [R3]
  ignore_quiet_a: assert property (@(posedge clk) disable iff (!rst_n)
    phase == st_ignore |=> io_oe == 4'h0 && !erase_start)
    else $error("ignored op acted"); // [R24]
  sleep_enter_a: assert property (@(posedge clk) disable iff (!rst_n)
    cs_rise && phase == st_data && opcode == deep_sleep_cmd
    |=> deep_sleep) else $error("no sleep"); // [R17]
  cont_exit_a: assert property (@(posedge clk) disable iff (!rst_n)
    $fell(continuous_mode) |-> $past(!toggling))
    else $error("bad exit"); // [R12]
  erase_pulse_a: assert property (@(posedge clk) disable iff (!rst_n)
    erase_start |=> !erase_start) else $error("erase long"); // [R15]
  status_read_c: cover property (@(posedge clk) disable iff (!rst_n)
    opcode == status_read_cmd && out_started);
  cont_mode_c: cover property (@(posedge clk) disable iff (!rst_n)
    $rose(continuous_mode));
  erase_c: cover property (@(posedge clk) disable iff (!rst_n)
    erase_start);
endmodule : flash_cmd_decoder

//--- bench/flash_host_model.sv
// Host-side link model that frames bytes on one or four lanes
`timescale 1ns/1ps
module flash_host_model (
  input wire logic clk,
  output logic cs_n_pin,
  output logic sclk_pin,
  output logic [3:0] io_in,
  input wire logic [3:0] io_out
);
  // ==========================================================
  // Idle state: deselected, clock parked low between frames
  initial begin
    cs_n_pin = 1'b1;
    sclk_pin = 1'b0;
    io_in = 4'h5;
  end
  // Half link period: 10 system clocks, 80 ns
  task automatic half();
    repeat (10) @(negedge clk);
  endtask : half
  // Whole bytes only inside one select frame
  task automatic frame(input logic on);
    half();
    cs_n_pin = ~on;
    io_in = ~io_in; // No stale lane value survives a frame edge
    half();
  endtask : frame
  // One byte, high bit first; quad width moves a nibble per clock
  task automatic xfer(input logic [7:0] b, input logic quad,
    output logic [7:0] r);
    int i;
    for (i = 0; i < (quad ? 2 : 8); i++) begin
      if (quad) io_in = (i == 0) ? b[7:4] : b[3:0];
      else io_in = {~io_in[3:1], b[7 - i]};
      half();
      sclk_pin = 1'b1;
      r = quad ? {r[3:0], io_out} : {r[6:0], io_out[1]};
      half();
      sclk_pin = 1'b0;
    end
  endtask : xfer
endmodule : flash_host_model

//--- bench/test_serial_flash_command_decoder.sv
// Self-checking bench for the flash command decoder
`timescale 1ns/1ps
module test_serial_flash_command_decoder;
  import flash_cmd_pkg::*;
  // ==========================================================
  // Stimulus and observed signals
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic quad = 1'b0;
  logic six = 1'b0;
  logic cs_n, sclk, we, ds, cm, es, ps, pv;
  logic [3:0] io_in, io_out, io_oe;
  logic [7:0] st, sec, pd, rx, data_seen;
  logic [2:0] ek, kind_seen;
  logic [23:0] oa, addr_seen;
  int n_erase = 0;
  int n_prog = 0;
  int n_byte = 0;
  int fail_count = 0;
  int checked = 0;
  always #4 clk = ~clk;
  // Short power-up delay keeps the run brief
  flash_cmd_decoder #(.power_up_cycles(20)) DUT (.clk(clk), .rst_n(rst_n),
    .cs_n_pin(cs_n), .sclk_pin(sclk), .io_in(io_in), .io_out(io_out),
    .io_oe(io_oe), .quad_command_mode(quad), .six_dummy(six),
    .write_enabled(we), .deep_sleep(ds), .continuous_mode(cm),
    .status(st), .security(sec), .erase_start(es), .program_start(ps),
    .erase_kind(ek), .op_addr(oa), .prog_data(pd), .prog_valid(pv));
  flash_host_model host (.clk(clk), .cs_n_pin(cs_n), .sclk_pin(sclk),
    .io_in(io_in), .io_out(io_out));
  // One-cycle pulses are latched here so no edge is missed
  always @(posedge clk) if (es === 1'b1) n_erase <= n_erase + 1;
  always @(posedge clk) if (es === 1'b1) kind_seen <= ek;
  always @(posedge clk) if (es === 1'b1) addr_seen <= oa;
  always @(posedge clk) if (ps === 1'b1) n_prog <= n_prog + 1;
  always @(posedge clk) if (pv === 1'b1) n_byte <= n_byte + 1;
  always @(posedge clk) if (pv === 1'b1) data_seen <= pd;
  // ==========================================================
  // Shared tasks
  task automatic chk(input logic [23:0] got, input logic [23:0] exp);
    checked++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // Opcode, then address bytes 12 13 14, then data bytes a5
  task automatic send(input logic [7:0] op, input int na, input int nd);
    int i;
    host.frame(1'b1);
    host.xfer(op, quad, rx);
    for (i = 0; i < na; i++) host.xfer(8'h12 + i[7:0], quad, rx);
    for (i = 0; i < nd; i++) host.xfer(8'ha5, quad, rx);
    host.frame(1'b0);
  endtask : send
  task automatic end_of_test();
    $display("Comparisons %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : end_of_test
  // ==========================================================
  // Scenarios
  task automatic t_reset();
    chk(st, status_reset);
    chk({we, ds, cm}, 3'h0);
    send(status_read_cmd, 0, 1);
    chk(rx, 8'h00);
  endtask : t_reset
  // Status written in single lane, read back in both widths; id and security reads
  task automatic t_status();
    send(write_enable_cmd, 0, 0);
    send(status_write_cmd, 0, 1);
    chk(st, 8'ha5);
    chk(we, 1'b0);
    send(status_read_cmd, 0, 1);
    chk(rx, 8'ha5);
    quad = 1'b1;
    send(status_read_cmd, 0, 1);
    chk(rx, 8'ha5);
    quad = 1'b0;
    send(read_identification_cmd, 0, 1);
    chk(rx, maker_code);
    send(security_reg_read_cmd, 0, 1);
    chk(rx, security_reset);
    chk(sec, security_reset);
  endtask : t_status
  // Enable then disable, single lane first and quad second
  task automatic t_wel();
    int q;
    for (q = 0; q < 2; q++) begin
      quad = q[0];
      send(write_enable_cmd, 0, 0);
      chk(we, 1'b1);
      send(write_disable_cmd, 0, 0);
      chk(we, 1'b0);
    end
    quad = 1'b0;
  endtask : t_wel
  // Every erase opcode, modes alternating
  task automatic t_erase();
    logic [7:0] ops [5] = '{sector_erase_cmd, half_block_erase_cmd,
      block_erase_cmd, chip_erase_cmd, chip_erase_alt_cmd};
    int i;
    int n;
    for (i = 0; i < 5; i++) begin
      quad = i[0];
      n = n_erase;
      send(write_enable_cmd, 0, 0);
      send(ops[i], (i < 3) ? 3 : 0, 0);
      chk(n_erase, n + 1);
      chk(kind_seen, (i < 3) ? i + 1 : 4);
      if (i < 3) chk(addr_seen, 24'h121314);
    end
    quad = 1'b0;
  endtask : t_erase
  // Program in single lane; quad-lane program refused in quad mode
  task automatic t_prog();
    send(write_enable_cmd, 0, 0);
    send(page_program_cmd, 3, 2);
    chk(n_prog, 1);
    chk(n_byte, 2);
    chk(data_seen, 8'ha5);
    quad = 1'b1;
    send(write_enable_cmd, 0, 0);
    send(quad_page_program_cmd, 3, 2);
    chk(n_prog, 1);
    chk(we, 1'b1);
    send(deep_sleep_cmd, 0, 0);
    chk(ds, 1'b1);
    send(deep_sleep_release_cmd, 0, 0);
    chk(ds, 1'b0);
    quad = 1'b0;
  endtask : t_prog
  // Toggling indicator enters, all-ones leaves; second frame has no opcode
  // Third frame uses six dummy clocks, so one more quiet transfer
  task automatic t_cont();
    logic [7:0] ind [3] = '{8'ha5, 8'hff, 8'h00};
    int k;
    int i;
    for (k = 0; k < 3; k++) begin
      six = (k == 2);
      host.frame(1'b1);
      if (k != 1) host.xfer(quad_lane_read_cmd, 1'b0, rx);
      for (i = 0; i < 3; i++) host.xfer(8'h00, 1'b1, rx);
      host.xfer(ind[k], 1'b1, rx);
      host.xfer(8'h00, 1'b1, rx); // Lanes held driven
      host.xfer(8'h00, 1'b1, rx);
      if (k == 2) chk(rx, 8'h00);
      if (k == 2) host.xfer(8'h00, 1'b1, rx);
      chk(io_oe, 4'hf);
      host.frame(1'b0);
      chk(rx, erased_byte);
      chk(cm, k == 0);
      chk(io_oe, 4'h0);
    end
    six = 1'b0;
  endtask : t_cont
  // ==========================================================
  // Main sequence and watchdog
  initial begin
    repeat (10) @(negedge clk);
    rst_n = 1'b1;
    repeat (30) @(negedge clk); // Past the power-up write delay
    t_reset();
    t_status();
    t_wel();
    t_erase();
    t_prog();
    t_cont();
    end_of_test();
  end
  initial begin
    #600000;
    fail_count++;
    end_of_test();
  end
endmodule : test_serial_flash_command_decoder
